/* slm_can_sleep_ctrl.sv */
// Sleep request and acknowledge logic of a CAN controller, with its AHB-Lite register slave.
// Assumes a protocol engine on hclk reporting activity and finished buffers; can_rx_pin is asynchronous.
`include "slm_regs.svh"

module slm_can_sleep_ctrl
    import slm_pkg::*;
(
    input  wire logic        hclk,             // Bus and controller clock
    input  wire logic        hresetn,          // Async reset, active low
    input  wire logic        hsel,             // Slave select
    input  wire logic [31:0] haddr,            // Byte address
    input  wire logic [1:0]  htrans,           // Transfer type
    input  wire logic        hwrite,           // Write when high
    input  wire logic [2:0]  hsize,            // Word transfers only
    input  wire logic [31:0] hwdata,           // Write data
    input  wire logic        hready,           // Bus ready
    output logic             hreadyout,        // Always ready
    output logic             hresp,            // Always OKAY
    output logic      [31:0] hrdata,           // Read data
    input  wire slm_eng_s    eng,              // Protocol engine status
    input  wire slm_rxmsg_s  rxq,              // Head of receive queue
    output logic             rxq_pop,          // Head taken into foreground
    input  wire logic        can_rx_pin,       // CAN receive pin
    output logic             can_transmit_pin, // CAN transmit pin
    output logic             proto_clk_en,     // Protocol clock enable
    output logic      [2:0]  tx_pending,       // Buffers scheduled
    output logic      [2:0]  tx_abort_req,     // Abort requests to engine
    output logic      [95:0] tx_buf_data,      // Transmit buffer words
    output logic             busoff_recovered, // Recovery done pulse
    output logic             irq               // Interrupt, active high
);

    slm_state_e  state_ff, nxt_state;
    logic [1:0]  sync_cnt_ff, nxt_sync_cnt;
    logic        sleep_request_bit_ff;
    logic [2:0]  tx_buffer_empty_flag_ff;
    logic [2:0]  abort_ff;
    logic        rx_buffer_full_flag_ff;
    logic [31:0] rx_foreground_buffer_ff;
    logic [31:0] txbuf_ff [3];
    logic [3:0]  irq_stat_ff, irq_en_ff;
    logic        wr_en_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        rx_s1_ff, rx_s2_ff;
    logic [5:0]  div_ff;
    logic [3:0]  rec_run_ff;
    logic [7:0]  seq_cnt_ff;
    logic        recover_ff;
    logic        can_transmit_pin_ff;

    // Bus decode
    wire        take     = hsel & hready & htrans[1];
    wire [7:0]  a        = haddr[7:0];
    wire        wr_ctrl  = wr_en_ff && wr_addr_ff == `SLM_OFF_CTRL;
    wire        wr_txe   = wr_en_ff && wr_addr_ff == `SLM_OFF_TXE;
    wire        wr_abort = wr_en_ff && wr_addr_ff == `SLM_OFF_ABORT;
    wire        wr_rxf   = wr_en_ff && wr_addr_ff == `SLM_OFF_RXF;
    wire        wr_iclr  = wr_en_ff && wr_addr_ff == `SLM_OFF_IRQ_CLR;
    wire        wr_ien   = wr_en_ff && wr_addr_ff == `SLM_OFF_IRQ_EN;
    wire [2:0]  wr_txb;
    assign wr_txb[0] = wr_en_ff && wr_addr_ff == `SLM_OFF_TXBUF0;
    assign wr_txb[1] = wr_en_ff && wr_addr_ff == `SLM_OFF_TXBUF1;
    assign wr_txb[2] = wr_en_ff && wr_addr_ff == `SLM_OFF_TXBUF2;

    wire        asleep    = state_ff == ST_SLEEP;
    wire        sleep_ack = asleep || state_ff == ST_SYNC_OUT;
    wire        all_empty = &tx_buffer_empty_flag_ff;
    // Idle means nothing scheduled, nothing on the wire either way
    wire        idle_ok   = all_empty && !eng.tx_active && !eng.rx_active;

    // Foreground load is blocked while asleep and while the old message is unread
    wire        rx_load   = rxq.valid && !rx_buffer_full_flag_ff && !asleep;

    wire [31:0] status_w  = {15'h0000, seq_cnt_ff[6:0], rec_run_ff, state_ff,
                             eng.bus_off, eng.rx_active, eng.tx_active};
    wire [31:0] ctrl_w    = {30'h00000000, sleep_ack, sleep_request_bit_ff};

    wire [31:0] rd_mux =
        (a == `SLM_OFF_CTRL)     ? ctrl_w :
        (a == `SLM_OFF_TXE)      ? {29'h00000000, tx_buffer_empty_flag_ff} :
        (a == `SLM_OFF_ABORT)    ? {29'h00000000, abort_ff} :
        (a == `SLM_OFF_RXF)      ? {31'h00000000, rx_buffer_full_flag_ff} :
        (a == `SLM_OFF_RXDATA)   ? rx_foreground_buffer_ff :
        (a == `SLM_OFF_STATUS)   ? status_w :
        (a == `SLM_OFF_IRQ_STAT) ? {28'h0000000, irq_stat_ff} :
        (a == `SLM_OFF_IRQ_EN)   ? {28'h0000000, irq_en_ff} :
        (a == `SLM_OFF_TXBUF0)   ? txbuf_ff[0] :
        (a == `SLM_OFF_TXBUF1)   ? txbuf_ff[1] :
        (a == `SLM_OFF_TXBUF2)   ? txbuf_ff[2] :
        32'h00000000;

    assign hreadyout   = 1'b1;
    assign hresp       = 1'b0;
    assign hrdata      = hrdata_ff;

    // Sleep state machine
    always_comb begin
        nxt_state    = state_ff;
        nxt_sync_cnt = sync_cnt_ff;
        unique case (state_ff)
            ST_AWAKE: begin
                if (sleep_request_bit_ff) begin
                    nxt_state    = ST_SYNC_IN;
                    nxt_sync_cnt = `SLM_SYNC_CYCLES - 2'h1;
                end
            end
            ST_SYNC_IN: begin
                if (sync_cnt_ff != 2'h0) begin
                    nxt_sync_cnt = sync_cnt_ff - 2'h1;
                end else if (!sleep_request_bit_ff) begin
                    nxt_state = ST_AWAKE;
                end else begin
                    nxt_state = ST_WAIT_IDL;
                end
            end
            ST_WAIT_IDL: begin
                // Buffers scheduled after the request still get sent first
                if (!sleep_request_bit_ff) begin
                    nxt_state = ST_AWAKE;
                end else if (idle_ok) begin
                    nxt_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (!sleep_request_bit_ff) begin
                    nxt_state    = ST_SYNC_OUT;
                    nxt_sync_cnt = `SLM_SYNC_CYCLES - 2'h1;
                end
            end
            ST_SYNC_OUT: begin
                if (sync_cnt_ff != 2'h0) begin
                    nxt_sync_cnt = sync_cnt_ff - 2'h1;
                end else begin
                    nxt_state = ST_AWAKE;
                end
            end
            default: begin
                nxt_state = ST_AWAKE;
            end
        endcase
    end

    wire [3:0] ev;
    assign ev[`SLM_EV_SLEEP]   = state_ff == ST_WAIT_IDL && nxt_state == ST_SLEEP;
    assign ev[`SLM_EV_WAKE]    = state_ff == ST_SYNC_OUT && nxt_state == ST_AWAKE;
    assign ev[`SLM_EV_RXLOAD]  = rx_load;
    assign ev[`SLM_EV_RECOVER] = recover_ff;

    assign irq              = |(irq_stat_ff & irq_en_ff);
    assign rxq_pop          = rx_load;
    assign proto_clk_en     = !asleep;
    assign tx_pending       = ~tx_buffer_empty_flag_ff;
    assign tx_abort_req     = asleep ? 3'h0 : abort_ff;
    assign tx_buf_data      = {txbuf_ff[2], txbuf_ff[1], txbuf_ff[0]};
    assign can_transmit_pin = can_transmit_pin_ff;
    assign busoff_recovered = recover_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff    <= ST_AWAKE;
            sync_cnt_ff <= 2'h0;
        end else begin
            state_ff    <= nxt_state;
            sync_cnt_ff <= nxt_sync_cnt;
        end
    end

    // Bus slave: address phase captured, write applied in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_en_ff   <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff  <= 32'h00000000;
        end else begin
            wr_en_ff   <= take & hwrite;
            wr_addr_ff <= a;
            if (take && !hwrite) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_request_bit_ff <= 1'b0;
            irq_en_ff            <= `SLM_IRQ_EN_RST;
        end else begin
            if (wr_ctrl) begin
                sleep_request_bit_ff <= hwdata[`SLM_CTRL_REQ_BIT];
            end
            if (wr_ien) begin
                irq_en_ff <= hwdata[3:0];
            end
        end
    end

    // Hardware wins over software in the same cycle: its set of empty and status flags, its clear of aborts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_buffer_empty_flag_ff <= `SLM_TXE_RST;
            abort_ff                <= 3'h0;
            irq_stat_ff             <= 4'h0;
        end else begin
            tx_buffer_empty_flag_ff <= (tx_buffer_empty_flag_ff & ~(wr_txe ? hwdata[2:0] : 3'h0))
                                       | eng.tx_done;
            abort_ff                <= (abort_ff | (wr_abort ? hwdata[2:0] & ~tx_buffer_empty_flag_ff : 3'h0))
                                       & ~eng.tx_done;
            irq_stat_ff             <= (irq_stat_ff & ~(wr_iclr ? hwdata[3:0] : 4'h0)) | ev;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_buffer_full_flag_ff  <= 1'b0;
            rx_foreground_buffer_ff <= 32'h00000000;
        end else begin
            if (rx_load) begin
                rx_buffer_full_flag_ff  <= 1'b1;
                rx_foreground_buffer_ff <= rxq.data;
            end else if (wr_rxf && hwdata[0]) begin
                rx_buffer_full_flag_ff  <= 1'b0;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `SLM_NUM_TXB; gi++) begin : g_txbuf
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    txbuf_ff[gi] <= 32'h00000000;
                end else if (wr_txb[gi]) begin
                    txbuf_ff[gi] <= hwdata;
                end
            end
        end
    endgenerate

    // Pin side; recessive is forced from the cycle sleep is entered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            can_transmit_pin_ff <= 1'b1;
            rx_s1_ff <= 1'b1;
            rx_s2_ff <= 1'b1;
        end else begin
            can_transmit_pin_ff <= (nxt_state == ST_SLEEP) ? 1'b1 : eng.tx_bit;
            rx_s1_ff <= can_rx_pin;
            rx_s2_ff <= rx_s1_ff;
        end
    end

    // Bus-off recovery: bit-rate tick only advances while protocol clocks run
    wire bit_tick = proto_clk_en && div_ff == `SLM_BIT_DIV - 6'h01;
    wire run_done = rx_s2_ff && rec_run_ff == `SLM_RECESSIVE_RUN - 4'h1;
    wire seq_done = seq_cnt_ff == `SLM_BUSOFF_SEQ - 8'h01;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_ff <= 6'h00;
        end else if (proto_clk_en) begin
            div_ff <= bit_tick ? 6'h00 : div_ff + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rec_run_ff <= 4'h0;
            seq_cnt_ff <= 8'h00;
            recover_ff <= 1'b0;
        end else begin
            recover_ff <= 1'b0;
            if (!eng.bus_off) begin
                rec_run_ff <= 4'h0;
                seq_cnt_ff <= 8'h00;
            end else if (bit_tick) begin
                if (!rx_s2_ff) begin
                    rec_run_ff <= 4'h0;
                end else if (run_done) begin
                    rec_run_ff <= 4'h0;
                    seq_cnt_ff <= seq_done ? 8'h00 : seq_cnt_ff + 8'h01;
                    recover_ff <= seq_done;
                end else begin
                    rec_run_ff <= rec_run_ff + 4'h1;
                end
            end
        end
    end

    property p_req_starts_sync;
        @(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_AWAKE && sleep_request_bit_ff) |=> state_ff == ST_SYNC_IN [*2];
    endproperty
    a_req_starts_sync: assert property (p_req_starts_sync) else $error("sleep entry skipped sync delay");

    property p_no_sleep_pending;
        @(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_WAIT_IDL && !all_empty) |=> state_ff != ST_SLEEP;
    endproperty
    a_no_sleep_pending: assert property (p_no_sleep_pending) else $error("slept with pending buffer");

    property p_no_sleep_rx;
        @(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_WAIT_IDL && eng.rx_active) |=> state_ff != ST_SLEEP;
    endproperty
    a_no_sleep_rx: assert property (p_no_sleep_rx) else $error("slept during reception");

    property p_idle_sleeps;
        @(posedge hclk) disable iff (!hresetn)
        (state_ff == ST_WAIT_IDL && sleep_request_bit_ff && idle_ok) |=> asleep && sleep_ack;
    endproperty
    a_idle_sleeps: assert property (p_idle_sleeps) else $error("idle controller did not sleep");

    property p_sleep_bits;
        @(posedge hclk) disable iff (!hresetn)
        asleep |-> ctrl_w[1] && (ctrl_w[0] || $fell(sleep_request_bit_ff));
    endproperty
    a_sleep_bits: assert property (p_sleep_bits) else $error("sleep bits not both set");

    property p_sleep_pins;
        @(posedge hclk) disable iff (!hresetn)
        asleep |-> !proto_clk_en && can_transmit_pin && tx_abort_req == 3'h0 && !rxq_pop;
    endproperty
    a_sleep_pins: assert property (p_sleep_pins) else $error("activity while asleep");

    property p_busoff_frozen;
        @(posedge hclk) disable iff (!hresetn)
        (asleep && eng.bus_off) |=> $stable(rec_run_ff) && $stable(seq_cnt_ff);
    endproperty
    a_busoff_frozen: assert property (p_busoff_frozen) else $error("recovery count moved in sleep");

    property p_rxf_clear;
        @(posedge hclk) disable iff (!hresetn)
        (asleep && wr_rxf && hwdata[0]) |=> !rx_buffer_full_flag_ff;
    endproperty
    a_rxf_clear: assert property (p_rxf_clear) else $error("full flag not cleared in sleep");

    property p_txe_clear;
        @(posedge hclk) disable iff (!hresetn)
        (asleep && wr_txe) |=> (tx_buffer_empty_flag_ff & $past(hwdata[2:0] & ~eng.tx_done)) == 3'h0;
    endproperty
    a_txe_clear: assert property (p_txe_clear) else $error("empty flag not cleared in sleep");

    property p_wake;
        @(posedge hclk) disable iff (!hresetn)
        (asleep && !sleep_request_bit_ff) |=> (sleep_ack && proto_clk_en) [*2] ##1 !sleep_ack;
    endproperty
    a_wake: assert property (p_wake) else $error("wake sequence wrong");

endmodule : slm_can_sleep_ctrl

/* slm_eng_model.sv */
// Behavioural protocol engine and CAN bus partner of the sleep controller.
// Assumes the shared hclk; transmit activity freezes while protocol clocks are stopped, rx_active still follows rx_busy.
module slm_eng_model
    import slm_pkg::*;
(
    input  wire logic       hclk,         // Shared clock
    input  wire logic       hresetn,      // Async reset, active low
    input  wire logic [2:0] tx_pending,   // Buffers scheduled
    input  wire logic [2:0] tx_abort_req, // Abort requests
    input  wire logic       proto_clk_en, // Protocol clock enable
    input  wire logic       rx_busy,      // Another node is sending
    input  wire logic       bus_off_in,   // Error state to report
    input  wire logic [7:0] tx_len,       // Frame length in cycles, minus one
    output slm_eng_s        eng           // Engine status
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_ff;
    logic [1:0] cur_ff;
    logic       act_ff;
    logic       gap_ff;
    logic [2:0] done_ff;
    logic [1:0] pick;

    assign pick = tx_pending[0] ? 2'h0 : (tx_pending[1] ? 2'h1 : 2'h2);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_ff  <= 8'h00;
            cur_ff  <= 2'h0;
            act_ff  <= 1'b0;
            gap_ff  <= 1'b0;
            done_ff <= 3'h0;
        end else if (proto_clk_en) begin
            done_ff <= 3'h0;
            gap_ff  <= 1'b0;
            if (act_ff) begin
                cnt_ff <= cnt_ff + 8'h01;
                if (cnt_ff == tx_len) begin
                    act_ff          <= 1'b0;
                    done_ff[cur_ff] <= 1'b1;
                    gap_ff          <= 1'b1;
                end
            // Gap lets the empty flags settle before the next pick
            end else if (!gap_ff && |(tx_abort_req & tx_pending)) begin
                done_ff <= tx_abort_req & tx_pending;
                gap_ff  <= 1'b1;
            end else if (!gap_ff && |tx_pending && !rx_busy) begin
                act_ff <= 1'b1;
                cur_ff <= pick;
                cnt_ff <= 8'h00;
            end
        end
    end

    assign eng = '{tx_active: act_ff, rx_active: rx_busy, bus_off: bus_off_in,
                   tx_bit: act_ff ? cnt_ff[0] : 1'b1, tx_done: done_ff & {3{proto_clk_en}}};
endmodule : slm_eng_model

/* slm_pkg.sv */
// Types shared by the CAN sleep controller.
// Assumes the protocol engine sits on the same clock as the controller.
package slm_pkg;

    typedef enum logic [2:0] {
        ST_AWAKE    = 3'b000,
        ST_SYNC_IN  = 3'b001,
        ST_WAIT_IDL = 3'b010,
        ST_SLEEP    = 3'b011,
        ST_SYNC_OUT = 3'b100
    } slm_state_e;

    typedef struct packed {
        logic       tx_active;
        logic       rx_active;
        logic       bus_off;
        logic       tx_bit;
        logic [2:0] tx_done;
    } slm_eng_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } slm_rxmsg_s;

endpackage : slm_pkg

/* slm_regs.svh */
// Register map, field positions, reset values and timing counts of the CAN sleep controller.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one aligned word per register.
`ifndef SLM_REGS_SVH
`define SLM_REGS_SVH

`define SLM_OFF_CTRL      8'h00
`define SLM_OFF_TXE       8'h04
`define SLM_OFF_ABORT     8'h08
`define SLM_OFF_RXF       8'h0C
`define SLM_OFF_RXDATA    8'h10
`define SLM_OFF_STATUS    8'h14
`define SLM_OFF_IRQ_STAT  8'h18
`define SLM_OFF_IRQ_CLR   8'h1C
`define SLM_OFF_IRQ_EN    8'h20
`define SLM_OFF_TXBUF0    8'h24
`define SLM_OFF_TXBUF1    8'h28
`define SLM_OFF_TXBUF2    8'h2C

`define SLM_CTRL_REQ_BIT  0
`define SLM_CTRL_ACK_BIT  1

`define SLM_NUM_TXB       3
`define SLM_NUM_EV        4
`define SLM_EV_SLEEP      0
`define SLM_EV_WAKE       1
`define SLM_EV_RXLOAD     2
`define SLM_EV_RECOVER    3

`define SLM_TXE_RST       3'h7
`define SLM_IRQ_EN_RST    4'h0

`define SLM_SYNC_CYCLES   2'h2
`define SLM_BIT_DIV       6'h28
`define SLM_RECESSIVE_RUN 4'hB
`define SLM_BUSOFF_SEQ    8'h80

`endif

/* test_can_sleep_mode_ctrl.sv */
// Self-checking bench of the CAN sleep controller: AHB-Lite master tasks and sleep scenarios.
// Assumes the engine model on hclk and the transmit pin looped back to the receive pin.
`include "slm_regs.svh"
module test_can_sleep_mode_ctrl
    import slm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    slm_eng_s    eng;
    slm_rxmsg_s  rxq = '0;
    logic        rxq_pop, can_pin, clk_en, recov, irq;
    logic [2:0]  tx_pending, abort_req;
    logic [95:0] bufs;
    logic        rx_busy = 1'b0;
    logic        bus_off = 1'b0;
    logic [7:0]  tx_len = 8'h08;
    int          bad_count = 0;
    int          cmp_count = 0;

    always #25 hclk = ~hclk;

    slm_can_sleep_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
        .hrdata(hrdata), .eng(eng), .rxq(rxq), .rxq_pop(rxq_pop), .can_rx_pin(can_pin),
        .can_transmit_pin(can_pin), .proto_clk_en(clk_en), .tx_pending(tx_pending), .tx_abort_req(abort_req),
        .tx_buf_data(bufs), .busoff_recovered(recov), .irq(irq));

    slm_eng_model partner (.hclk(hclk), .hresetn(hresetn), .tx_pending(tx_pending), .tx_abort_req(abort_req),
        .proto_clk_en(clk_en), .rx_busy(rx_busy), .bus_off_in(bus_off), .tx_len(tx_len), .eng(eng));

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s saw %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp, what);
    endtask : rd_chk

    task automatic wait_en(input logic lvl, input int lim, output int n);
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (clk_en !== lvl && n < lim);
    endtask : wait_en

    task automatic enter_sleep(input int lim);
        int n;
        wr(`SLM_OFF_CTRL, 32'h1);
        wait_en(1'b0, lim, n);
        check(clk_en, 1'b0, "sleeping");
    endtask : enter_sleep

    task automatic wake;
        logic [31:0] q;
        int n;
        wr(`SLM_OFF_CTRL, 32'h0);
        n = 0;
        do begin
            bus(1'b0, `SLM_OFF_CTRL, 32'h0, q);
            n++;
        end while (q[`SLM_CTRL_ACK_BIT] !== 1'b0 && n < 20);
        check({q[1:0], clk_en}, 3'b001, "awake");
    endtask : wake

    task automatic t_reset;
        rd_chk(`SLM_OFF_CTRL, 32'h0, "ctrl");
        rd_chk(`SLM_OFF_TXE, {29'h0, `SLM_TXE_RST}, "txe");
        rd_chk(`SLM_OFF_IRQ_EN, 32'h0, "irq enable");
        wr(8'h3C, 32'hFFFFFFFF);
        rd_chk(8'h3C, 32'h0, "unmapped");
        check({hresp, can_pin, clk_en, tx_pending, abort_req, irq}, 10'h180, "idle pins");
    endtask : t_reset

    task automatic t_idle;
        int n;
        wr(`SLM_OFF_IRQ_EN, 32'h3);
        wr(`SLM_OFF_CTRL, 32'h1);
        wait_en(1'b0, 50, n);
        check(n, 5, "entry delay");
        repeat (30) @(posedge hclk);
        check({clk_en, can_pin, irq}, 3'b011, "asleep pins");
        rd_chk(`SLM_OFF_CTRL, 32'h3, "req and ack");
        rd_chk(`SLM_OFF_IRQ_STAT, 32'h1, "sleep event");
        wr(`SLM_OFF_IRQ_CLR, 32'h1);
        @(negedge hclk) check(irq, 1'b0, "irq cleared");
        wake();
        rd_chk(`SLM_OFF_IRQ_STAT, 32'h2, "wake event");
        wr(`SLM_OFF_IRQ_CLR, 32'h3);
        wr(`SLM_OFF_IRQ_EN, 32'h0);
    endtask : t_idle

    task automatic t_tx;
        int n;
        @(posedge hclk) tx_len <= 8'h3C;
        wr(`SLM_OFF_TXBUF0, 32'hA5A50001);
        wr(`SLM_OFF_TXE, 32'h3);
        n = 0;
        while (eng.tx_active !== 1'b1 && n < 20) begin
            @(negedge hclk);
            n++;
        end
        wr(`SLM_OFF_ABORT, 32'h2);
        wr(`SLM_OFF_CTRL, 32'h1);
        wait_en(1'b0, 1000, n);
        check(n > 20, 1'b1, "waited for frame");
        check(tx_pending, 3'h0, "sent before sleep");
        rd_chk(`SLM_OFF_TXE, 32'h7, "all empty");
        check(bufs[31:0], 32'hA5A50001, "buf0 word");
        wake();
    endtask : t_tx

    task automatic t_rx;
        int n;
        @(posedge hclk) rx_busy <= 1'b1;
        wr(`SLM_OFF_CTRL, 32'h1);
        wait_en(1'b0, 100, n);
        check(clk_en, 1'b1, "still receiving");
        @(posedge hclk) rx_busy <= 1'b0;
        wait_en(1'b0, 10, n);
        check(clk_en, 1'b0, "sleep at idle");
        wake();
    endtask : t_rx

    task automatic t_bufs;
        int n;
        @(posedge hclk) rxq <= '{valid: 1'b1, data: 32'h11112222};
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (rxq_pop !== 1'b1 && n < 10);
        @(posedge hclk) rxq <= '{valid: 1'b1, data: 32'h33334444};
        enter_sleep(50);
        rd_chk(`SLM_OFF_RXDATA, 32'h11112222, "held message");
        rd_chk(`SLM_OFF_RXF, 32'h1, "full");
        wr(`SLM_OFF_RXF, 32'h1);
        rd_chk(`SLM_OFF_RXF, 32'h0, "full cleared");
        wr(`SLM_OFF_TXBUF1, 32'h5A5A1234);
        rd_chk(`SLM_OFF_TXBUF1, 32'h5A5A1234, "buf1 access");
        wr(`SLM_OFF_TXE, 32'h2);
        rd_chk(`SLM_OFF_TXE, 32'h5, "scheduled asleep");
        wr(`SLM_OFF_ABORT, 32'h2);
        n = 0;
        repeat (20) begin
            @(negedge hclk);
            n += int'(rxq_pop !== 1'b0 || abort_req !== 3'h0);
        end
        check(n, 0, "no load or abort");
        rd_chk(`SLM_OFF_TXE, 32'h5, "abort held off");
        rd_chk(`SLM_OFF_RXDATA, 32'h11112222, "foreground kept");
        check({irq, can_pin}, 2'b01, "masked irq");
        wake();
        repeat (2) @(posedge hclk);
        rxq <= '0;
        rd_chk(`SLM_OFF_RXDATA, 32'h33334444, "load after wake");
        repeat (100) @(posedge hclk);
        rd_chk(`SLM_OFF_TXE, 32'h7, "buf1 done after wake");
        check(bufs[63:32], 32'h5A5A1234, "buf1 word");
    endtask : t_bufs

    task automatic t_busoff;
        logic [31:0] s1;
        logic [31:0] s2;
        int n;
        @(posedge hclk) bus_off <= 1'b1;
        repeat (500) @(posedge hclk);
        enter_sleep(50);
        bus(1'b0, `SLM_OFF_STATUS, 32'h0, s1);
        repeat (400) @(posedge hclk);
        bus(1'b0, `SLM_OFF_STATUS, 32'h0, s2);
        check(s2[16:6], s1[16:6], "count frozen");
        check({s1[2], s1[16:6] != 11'h0}, 2'b11, "count ran");
        wake();
        repeat (400) @(posedge hclk);
        bus(1'b0, `SLM_OFF_STATUS, 32'h0, s2);
        check(s2[16:6] != s1[16:6], 1'b1, "count resumes");
        wr(`SLM_OFF_IRQ_CLR, 32'hF);
        n = 0;
        while (recov !== 1'b1 && n < 60000) begin
            @(negedge hclk);
            n++;
        end
        check(recov, 1'b1, "recovered after full count");
        check(n > 50000, 1'b1, "recovery span");
        rd_chk(`SLM_OFF_IRQ_STAT, 32'h8, "recover event");
        @(posedge hclk) bus_off <= 1'b0;
    endtask : t_busoff

    initial begin
        repeat (80000) @(posedge hclk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_idle();
        t_tx();
        t_rx();
        t_bufs();
        t_busoff();
        tally_and_finish();
    end
endmodule : test_can_sleep_mode_ctrl
